// File: core/sscfm_defines.vh
// Purpose: shared constants of the command frame mapper
// Assumes: included by bare name from core files
// Notes:   definitions only
`ifndef SSCFM_DEFINES_VH
`define SSCFM_DEFINES_VH

// ----------------------------------------------------------------
// field widths
// ----------------------------------------------------------------
`define SSCFM_ADDR_W   64
`define SSCFM_LUN_W    64
`define SSCFM_TAG_W    16
`define SSCFM_CDB_W    128
`define SSCFM_ATTR_W   3
`define SSCFM_PRIO_W   4
`define SSCFM_LEN_W    33
`define SSCFM_BEAT_W   4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSCFM_LEN_ZERO  33'h000000000
`define SSCFM_PRIO_ZERO 4'h0
`define SSCFM_ATTR_ZERO 3'h0

// ----------------------------------------------------------------
// initiator states
// ----------------------------------------------------------------
`define SSCFM_ST_W     2
`define SSCFM_ST_IDLE  2'h0
`define SSCFM_ST_SEND  2'h1
`define SSCFM_ST_BURST 2'h2

`endif

// File: core/sscfm_burst_credit.v
// Purpose: first-burst byte credit counter
// Assumes: load and beat come from logic on sys_clk
// Notes:   credit saturates at zero on an oversized last beat
`timescale 1ns/1ps
`default_nettype none
`include "sscfm_defines.vh"

module sscfm_burst_credit #(
  parameter LEN_W  = `SSCFM_LEN_W,
  parameter BEAT_W = `SSCFM_BEAT_W
) (
  input  wire              sys_clk,
  input  wire              rst,
  input  wire              load,
  input  wire [LEN_W-1:0]  load_bytes,
  input  wire              beat,
  input  wire [BEAT_W-1:0] beat_bytes,
  output reg               active_q,
  output reg  [LEN_W-1:0]  left_q
);

  // ----------------------------------------------------------------
  // credit
  // ----------------------------------------------------------------
  wire [LEN_W-1:0] beat_ext;
  reg  [LEN_W-1:0] left_d;

  assign beat_ext = {{(LEN_W-BEAT_W){1'b0}}, beat_bytes};

  always @* begin
    left_d = left_q;
    if (load) begin
      left_d = load_bytes;
    end else if (beat && active_q) begin
      if (beat_ext >= left_q) begin
        left_d = `SSCFM_LEN_ZERO;
      end else begin
        left_d = left_q - beat_ext;
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      left_q   <= `SSCFM_LEN_ZERO;
      active_q <= 1'b0;
    end else begin
      left_q   <= left_d;
      active_q <= (left_d != `SSCFM_LEN_ZERO);
    end
  end

endmodule // sscfm_burst_credit

`default_nettype wire

// File: core/sscfm_top.v
// Purpose: command request to COMMAND frame fields, and received
//          COMMAND frame to command indication
// Assumes: one clock, all ports driven by logic on sys_clk
// Notes:   one request and one indication held at a time
//
// How it works
// R1 - each accepted request yields exactly one outgoing COMMAND frame
// R2 - frame source is the nexus initiator, destination the nexus target
// R3 - nexus logical unit and queue tag go to LUN and TAG fields
// R4 - CDB copied unchanged into the frame CDB field
// R5 - requested task attribute goes to the TASK ATTRIBUTE field
// R6 - supplied task priority goes to TASK PRIORITY, else zero
// R7 - client keeps buffer sizes at or below two to the thirty-two
// R8 - data-out buffer stays local; no frame field carries it
// R9 - first burst sets enable bit, sends credit without transfer ready
// R10 - a received COMMAND frame raises one indication to device server
// R11 - indication names initiator, target, received LUN and TAG
// R12 - received CDB passed to device server as indication CDB
// R13 - received task attribute and priority reported unchanged
// R14 - first-burst flag from enable bit and configured first-burst size
// R15 - command reference number never used in the indication
// R16 - valid/ready handshakes on one clock; reset clears pending items
`timescale 1ns/1ps
`default_nettype none
`include "sscfm_defines.vh"

module sscfm_top #(
  parameter ADDR_W = `SSCFM_ADDR_W,
  parameter LUN_W  = `SSCFM_LUN_W,
  parameter TAG_W  = `SSCFM_TAG_W,
  parameter CDB_W  = `SSCFM_CDB_W,
  parameter ATTR_W = `SSCFM_ATTR_W,
  parameter PRIO_W = `SSCFM_PRIO_W,
  parameter LEN_W  = `SSCFM_LEN_W,
  parameter BEAT_W = `SSCFM_BEAT_W
) (
  input  wire              sys_clk,
  input  wire              rst,
  // first-burst size configured for the peer
  input  wire [LEN_W-1:0]  cfg_fb_bytes,
  // command request from the application client
  input  wire              req_valid,
  output reg               req_ready_q,
  input  wire [ADDR_W-1:0] req_init_addr,
  input  wire [ADDR_W-1:0] req_tgt_addr,
  input  wire [LUN_W-1:0]  req_lun,
  input  wire [TAG_W-1:0]  req_tag,
  input  wire [CDB_W-1:0]  req_cdb,
  input  wire [ATTR_W-1:0] req_attr,
  input  wire              req_prio_vld,
  input  wire [PRIO_W-1:0] req_prio,
  input  wire              req_fb_en,
  input  wire [LEN_W-1:0]  req_dout_bytes,
  // outgoing COMMAND frame fields
  output reg               tx_valid_q,
  input  wire              tx_ready,
  output reg  [ADDR_W-1:0] tx_src_addr_q,
  output reg  [ADDR_W-1:0] tx_dst_addr_q,
  output reg  [LUN_W-1:0]  tx_lun_q,
  output reg  [TAG_W-1:0]  tx_tag_q,
  output reg  [CDB_W-1:0]  tx_cdb_q,
  output reg  [ATTR_W-1:0] tx_attr_q,
  output reg  [PRIO_W-1:0] tx_prio_q,
  output reg               tx_fb_en_q,
  // unsolicited write data beats of the first burst
  input  wire              wr_valid,
  input  wire [BEAT_W-1:0] wr_bytes,
  output wire              wr_ready_q,
  output wire [LEN_W-1:0]  wr_left_q,
  // received COMMAND frame fields
  input  wire              rx_valid,
  output reg               rx_ready_q,
  input  wire [ADDR_W-1:0] rx_src_addr,
  input  wire [ADDR_W-1:0] rx_dst_addr,
  input  wire [LUN_W-1:0]  rx_lun,
  input  wire [TAG_W-1:0]  rx_tag,
  input  wire [CDB_W-1:0]  rx_cdb,
  input  wire [ATTR_W-1:0] rx_attr,
  input  wire [PRIO_W-1:0] rx_prio,
  input  wire              rx_fb_en,
  // command indication to the device server
  output reg               ind_valid_q,
  input  wire              ind_ready,
  output reg  [ADDR_W-1:0] ind_init_addr_q,
  output reg  [ADDR_W-1:0] ind_tgt_addr_q,
  output reg  [LUN_W-1:0]  ind_lun_q,
  output reg  [TAG_W-1:0]  ind_tag_q,
  output reg  [CDB_W-1:0]  ind_cdb_q,
  output reg  [ATTR_W-1:0] ind_attr_q,
  output reg  [PRIO_W-1:0] ind_prio_q,
  output reg               ind_fb_q,
  output reg  [LEN_W-1:0]  ind_fb_bytes_q,
  // first-burst data still expected from the initiator
  input  wire              rxd_valid,
  input  wire [BEAT_W-1:0] rxd_bytes,
  output wire              rxd_pending_q,
  output wire [LEN_W-1:0]  rxd_left_q
);

  // ----------------------------------------------------------------
  // initiator request sequencing
  // ----------------------------------------------------------------
  localparam ST_IDLE  = `SSCFM_ST_IDLE;
  localparam ST_SEND  = `SSCFM_ST_SEND;
  localparam ST_BURST = `SSCFM_ST_BURST;

  reg  [`SSCFM_ST_W-1:0] st_q;
  reg  [`SSCFM_ST_W-1:0] st_d;
  reg  [LEN_W-1:0]       credit_q;
  wire                   req_take;
  wire                   tx_done;
  wire                   burst_load;
  wire                   wr_beat;

  assign req_take   = req_valid && req_ready_q; // R16
  assign tx_done    = tx_valid_q && tx_ready;
  assign burst_load = tx_done && tx_fb_en_q &&
                      (credit_q != `SSCFM_LEN_ZERO);
  assign wr_beat    = wr_valid && wr_ready_q;

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (req_take) begin
          st_d = ST_SEND; // R1
        end
      end
      ST_SEND: begin
        if (burst_load) begin
          st_d = ST_BURST; // R9
        end else if (tx_done) begin
          st_d = ST_IDLE;
        end
      end
      ST_BURST: begin
        // next request waits until the unsolicited data is out
        if (!wr_ready_q && !burst_load) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q        <= ST_IDLE;
      req_ready_q <= 1'b0;
      tx_valid_q  <= 1'b0; // R16
    end else begin
      st_q        <= st_d;
      req_ready_q <= (st_d == ST_IDLE);
      if (req_take) begin
        tx_valid_q <= 1'b1; // R1
      end else if (tx_done) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outgoing frame fields
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_src_addr_q <= {ADDR_W{1'b0}};
      tx_dst_addr_q <= {ADDR_W{1'b0}};
      tx_lun_q      <= {LUN_W{1'b0}};
      tx_tag_q      <= {TAG_W{1'b0}};
      tx_cdb_q      <= {CDB_W{1'b0}};
      tx_attr_q     <= `SSCFM_ATTR_ZERO;
      tx_prio_q     <= `SSCFM_PRIO_ZERO;
      tx_fb_en_q    <= 1'b0;
      credit_q      <= `SSCFM_LEN_ZERO;
    end else if (req_take) begin
      tx_src_addr_q <= req_init_addr; // R2
      tx_dst_addr_q <= req_tgt_addr; // R2
      tx_lun_q      <= req_lun; // R3
      tx_tag_q      <= req_tag; // R3
      tx_cdb_q      <= req_cdb; // R4
      tx_attr_q     <= req_attr; // R5
      tx_prio_q     <= req_prio_vld ? req_prio
                                    : `SSCFM_PRIO_ZERO; // R6
      tx_fb_en_q    <= req_fb_en; // R9
      // buffer size only sizes the local burst, never a field
      if (req_dout_bytes < cfg_fb_bytes) begin
        credit_q <= req_dout_bytes; // R8
      end else begin
        credit_q <= cfg_fb_bytes; // R9
      end
    end
  end

  // ----------------------------------------------------------------
  // initiator first-burst credit
  // ----------------------------------------------------------------
  // sizes fit LEN_W, so two to the thirty-three minus one is the largest credit
  sscfm_burst_credit #(
    .LEN_W  (LEN_W),
    .BEAT_W (BEAT_W)
  ) u_init_credit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .load       (burst_load), // R7
    .load_bytes (credit_q),
    .beat       (wr_beat),
    .beat_bytes (wr_bytes),
    .active_q   (wr_ready_q),
    .left_q     (wr_left_q)
  );

  // ----------------------------------------------------------------
  // target indication
  // ----------------------------------------------------------------
  wire rx_take;
  wire ind_done;
  wire fb_arm;

  assign rx_take  = rx_valid && rx_ready_q; // R16
  assign ind_done = ind_valid_q && ind_ready;
  assign fb_arm   = rx_take && rx_fb_en &&
                    (cfg_fb_bytes != `SSCFM_LEN_ZERO);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ind_valid_q <= 1'b0; // R16
      rx_ready_q  <= 1'b0;
    end else begin
      if (rx_take) begin
        ind_valid_q <= 1'b1; // R10
        rx_ready_q  <= 1'b0;
      end else if (ind_done) begin
        ind_valid_q <= 1'b0;
        rx_ready_q  <= 1'b1;
      end else begin
        rx_ready_q  <= !ind_valid_q;
      end
    end
  end

  // reference number has no port; only these fields form it
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ind_init_addr_q <= {ADDR_W{1'b0}};
      ind_tgt_addr_q  <= {ADDR_W{1'b0}};
      ind_lun_q       <= {LUN_W{1'b0}};
      ind_tag_q       <= {TAG_W{1'b0}};
      ind_cdb_q       <= {CDB_W{1'b0}};
      ind_attr_q      <= `SSCFM_ATTR_ZERO;
      ind_prio_q      <= `SSCFM_PRIO_ZERO;
      ind_fb_q        <= 1'b0;
      ind_fb_bytes_q  <= `SSCFM_LEN_ZERO;
    end else if (rx_take) begin
      ind_init_addr_q <= rx_src_addr; // R11
      ind_tgt_addr_q  <= rx_dst_addr; // R11
      ind_lun_q       <= rx_lun; // R11
      ind_tag_q       <= rx_tag; // R11
      ind_cdb_q       <= rx_cdb; // R12
      ind_attr_q      <= rx_attr; // R13
      ind_prio_q      <= rx_prio; // R13
      ind_fb_q        <= fb_arm; // R14
      ind_fb_bytes_q  <= fb_arm ? cfg_fb_bytes
                                : `SSCFM_LEN_ZERO; // R14 R15
    end
  end

  // ----------------------------------------------------------------
  // target first-burst arrival tracking
  // ----------------------------------------------------------------
  sscfm_burst_credit #(
    .LEN_W  (LEN_W),
    .BEAT_W (BEAT_W)
  ) u_tgt_credit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .load       (fb_arm), // R14
    .load_bytes (cfg_fb_bytes),
    .beat       (rxd_valid),
    .beat_bytes (rxd_bytes),
    .active_q   (rxd_pending_q),
    .left_q     (rxd_left_q)
  );

endmodule // sscfm_top

`default_nettype wire

// File: testbench/sscfm_sva.sv
// Purpose: port checks of the command frame mapper
// Assumes: one clock, bound to sscfm_top
// Notes:   figures follow the hand-over timing
`timescale 1ns/1ps
`default_nettype none
module sscfm_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_ready_q,
  input wire logic [15:0] req_tag,
  input wire logic        tx_valid_q,
  input wire logic        tx_ready,
  input wire logic [15:0] tx_tag_q,
  input wire logic        wr_valid,
  input wire logic [3:0]  wr_bytes,
  input wire logic        wr_ready_q,
  input wire logic [32:0] wr_left_q,
  input wire logic        rx_valid,
  input wire logic        rx_ready_q,
  input wire logic [15:0] rx_tag,
  input wire logic        rx_fb_en,
  input wire logic [32:0] cfg_fb_bytes,
  input wire logic        ind_valid_q,
  input wire logic        ind_ready,
  input wire logic [15:0] ind_tag_q,
  input wire logic        ind_fb_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_take_frame: assert property (
    req_valid && req_ready_q |=> tx_valid_q && !req_ready_q)
    else $error("frame not raised");
  a_tag_copy: assert property (
    req_valid && req_ready_q |=> tx_tag_q == $past(req_tag))
    else $error("frame tag wrong");
  a_tx_stand: assert property (
    tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_tag_q))
    else $error("frame dropped early");
  a_credit_dec: assert property (
    wr_valid && wr_ready_q && wr_left_q > wr_bytes |=>
    wr_left_q == $past(wr_left_q) - $past(wr_bytes))
    else $error("credit not reduced");
  a_rx_ind: assert property (
    rx_valid && rx_ready_q |=>
    ind_valid_q && !rx_ready_q && ind_tag_q == $past(rx_tag))
    else $error("indication wrong");
  a_ind_stand: assert property (
    ind_valid_q && !ind_ready |=> ind_valid_q [*1] ##0 !rx_ready_q)
    else $error("indication dropped");
  a_fb_flag: assert property (
    rx_valid && rx_ready_q |=>
    ind_fb_q == ($past(rx_fb_en) && $past(cfg_fb_bytes) != 33'h0))
    else $error("burst flag wrong");
  a_ind_done: assert property (
    ind_valid_q && ind_ready |=> !ind_valid_q && rx_ready_q)
    else $error("indication not released");
endmodule // sscfm_chk
bind sscfm_top sscfm_chk u_chk (.sys_clk, .rst, .req_valid, .req_ready_q,
  .req_tag, .tx_valid_q, .tx_ready, .tx_tag_q, .wr_valid, .wr_bytes,
  .wr_ready_q, .wr_left_q, .rx_valid, .rx_ready_q, .rx_tag, .rx_fb_en,
  .cfg_fb_bytes, .ind_valid_q, .ind_ready, .ind_tag_q, .ind_fb_q);
`default_nettype wire

// File: testbench/sscfm_peer.sv
// Purpose: remote port that returns each sent frame as a received one
// Assumes: stall holds back frame acceptance
// Notes:   released lines show inverted data
`timescale 1ns/1ps
`default_nettype none
module sscfm_peer (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         stall,
  input  wire logic         tx_valid_q,
  input  wire logic [343:0] tx_f,
  output var  logic         tx_ready,
  output var  logic         rx_valid,
  output var  logic [343:0] rx_f,
  input  wire logic         rx_ready_q,
  input  wire logic         wr_valid,
  input  wire logic         wr_ready_q,
  input  wire logic [3:0]   wr_bytes,
  output var  logic         rxd_valid,
  output var  logic [3:0]   rxd_bytes
);
  logic took_q;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      took_q <= 1'b0;
      rxd_valid <= 1'b0;
      rxd_bytes <= 4'h0;
    end else begin
      took_q <= rx_valid && rx_ready_q;
      rxd_valid <= wr_valid && wr_ready_q;
      rxd_bytes <= (wr_valid && wr_ready_q) ? wr_bytes : ~rxd_bytes;
    end
  end
  always @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_f <= '0;
    end else begin
      if (tx_valid_q && !tx_ready && !rx_valid && !stall) begin
        tx_ready <= 1'b1;
        rx_f <= tx_f;
      end else
        tx_ready <= 1'b0;
      if (tx_ready)
        rx_valid <= 1'b1;
      else if (took_q) begin
        rx_valid <= 1'b0;
        rx_f <= ~rx_f;
      end
    end
  end
endmodule // sscfm_peer
`default_nettype wire

// File: testbench/sscfm_top_tb.sv
// Purpose: self-checking bench of the command frame mapper
// Assumes: peer loops frames back, so indications mirror requests
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module sscfm_top_tb;
  logic sys_clk = 0, rst = 1, stall = 0, req_valid = 0, req_prio_vld = 0;
  logic req_fb_en = 0, wr_valid = 0, ind_ready = 0;
  logic [15:0] req_tag = 0;
  logic [3:0]  wr_bytes = 0;
  logic [32:0] cfg_fb_bytes = 0, req_dout_bytes = 0;
  wire req_ready_q, tx_valid_q, tx_ready, tx_fb_en_q, wr_ready_q, rx_valid;
  wire rx_ready_q, rx_fb_en, ind_valid_q, ind_fb_q, rxd_valid, rxd_pending_q;
  wire [63:0] tx_src_addr_q, tx_dst_addr_q, tx_lun_q, rx_src_addr;
  wire [63:0] rx_dst_addr, rx_lun, ind_init_addr_q, ind_tgt_addr_q, ind_lun_q;
  wire [15:0] tx_tag_q, rx_tag, ind_tag_q;
  wire [127:0] tx_cdb_q, rx_cdb, ind_cdb_q;
  wire [2:0] tx_attr_q, rx_attr, ind_attr_q;
  wire [3:0] tx_prio_q, rx_prio, ind_prio_q, rxd_bytes;
  wire [32:0] wr_left_q, ind_fb_bytes_q, rxd_left_q;
  wire [63:0] req_init_addr = {4{~req_tag}};
  wire [63:0] req_tgt_addr = {4{req_tag ^ 16'h5A5A}};
  wire [63:0] req_lun = {4{req_tag}};
  wire [127:0] req_cdb = {8{req_tag}};
  wire [2:0] req_attr = req_tag[2:0];
  wire [3:0] req_prio = req_tag[7:4];
  int fail_count = 0, n_checks = 0, cyc = 0;
  sscfm_top u_dut (.*);
  sscfm_peer u_peer (.sys_clk, .rst, .stall, .tx_valid_q, .tx_ready,
    .tx_f({tx_src_addr_q, tx_dst_addr_q, tx_lun_q, tx_tag_q, tx_cdb_q,
           tx_attr_q, tx_prio_q, tx_fb_en_q}), .rx_valid, .rx_ready_q,
    .rx_f({rx_src_addr, rx_dst_addr, rx_lun, rx_tag, rx_cdb, rx_attr,
           rx_prio, rx_fb_en}), .wr_valid, .wr_ready_q, .wr_bytes,
    .rxd_valid, .rxd_bytes);
  always #4 sys_clk = ~sys_clk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      finish_test;
    end
  end
  task automatic chk(input logic [127:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one command end to end, with an optional first burst of 7-byte beats
  task automatic cmd(input logic [15:0] t, input logic pv, fb,
                     input logic [32:0] dout, cred);
    logic [32:0] left, sent;
    @(negedge sys_clk);
    req_tag = t;
    req_prio_vld = pv;
    req_fb_en = fb;
    req_dout_bytes = dout;
    req_valid = 1;
    while (req_ready_q !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    req_valid = 0;
    left = cred;
    sent = 0;
    if (cred != 0) begin
      while (wr_ready_q !== 1'b1) @(negedge sys_clk);
      chk(wr_left_q, cred);
      wr_bytes = 4'h7;
      wr_valid = 1;
      while (left != 0) begin
        @(posedge sys_clk);
        left = left > 7 ? left - 7 : 0;
        sent = sent + 7;
        @(negedge sys_clk);
        chk(wr_left_q, left);
      end
      wr_valid = 0;
      chk(wr_ready_q, 1'b0);
    end
    while (ind_valid_q !== 1'b1) @(negedge sys_clk);
    chk({ind_init_addr_q, ind_tgt_addr_q}, {{4{~t}}, {4{t ^ 16'h5A5A}}});
    chk({ind_lun_q, ind_tag_q}, {{4{t}}, t});
    chk(ind_cdb_q, {8{t}});
    chk(ind_attr_q, t[2:0]);
    chk(ind_prio_q, pv ? t[7:4] : 4'h0);
    chk({ind_fb_q, ind_fb_bytes_q},
        (fb && cfg_fb_bytes != 0) ? {1'b1, cfg_fb_bytes} : 34'h0);
    repeat (3) @(negedge sys_clk);
    chk(ind_valid_q, 1'b1);
    ind_ready = 1;
    @(negedge sys_clk);
    ind_ready = 0;
    chk(ind_valid_q, 1'b0);
    chk(rxd_left_q, (fb && cfg_fb_bytes > sent) ? cfg_fb_bytes - sent
        : 33'h0);
    chk(rxd_pending_q, fb && cfg_fb_bytes > sent);
  endtask
  task automatic s_plain;
    cmd(16'h1234, 1'b1, 1'b0, 33'h0, 33'h0);
    cmd(16'hABCD, 1'b0, 1'b0, 33'h0, 33'h0);
  endtask
  task automatic s_burst;
    cfg_fb_bytes = 33'h14;
    cmd(16'h0F0F, 1'b1, 1'b1, 33'h100, 33'h14);
    cmd(16'h00F1, 1'b1, 1'b1, 33'h5, 33'h5);
    cmd(16'h5151, 1'b0, 1'b1, 33'h100000000, 33'h14);
    cfg_fb_bytes = 33'h0;
    cmd(16'h7777, 1'b1, 1'b1, 33'h100, 33'h0);
  endtask
  task automatic s_stall;
    @(negedge sys_clk);
    stall = 1;
    fork
      cmd(16'h4B4B, 1'b1, 1'b0, 33'h0, 33'h0);
      begin
        repeat (8) @(negedge sys_clk);
        chk({tx_valid_q, req_ready_q}, 2'b10);
        stall = 0;
      end
    join
  endtask
  task automatic s_reset;
    stall = 1;
    req_tag = 16'h2222;
    req_valid = 1;
    @(negedge sys_clk);
    req_valid = 0;
    @(negedge sys_clk);
    chk(tx_valid_q, 1'b1);
    rst = 1;
    @(negedge sys_clk);
    chk({tx_valid_q, req_ready_q, ind_valid_q}, 3'b000);
    rst = 0;
    stall = 0;
    repeat (2) @(negedge sys_clk);
    chk({tx_valid_q, req_ready_q}, 2'b01);
    cmd(16'h3C3C, 1'b1, 1'b0, 33'h0, 33'h0);
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 0;
    repeat (2) @(negedge sys_clk);
    s_plain;
    s_burst;
    s_stall;
    s_reset;
    finish_test;
  end
endmodule // sscfm_top_tb
`default_nettype wire
